// ---- clrid_pkg.sv ----
// Constants, types and opcodes for the logic/rotate/interrupt-mask execution block
// Behaviour
// - Register logical ops 10100/10101/10110/10111 SSS combine with accumulator in 4 cycles
// - Source 110 takes memory operand and completes in 7 cycles
// - Immediate logical ops use next byte against accumulator, 7 cycles
// - Rotates left, right, left via carry, right via carry, 4 cycles
// - Mask set takes accumulator as interrupt control word
// - Mask-set bit 4 clears high vector edge latch
// - Mask-set bit 3 enables loading the three mask bits
// - Mask-set bits 2,1,0 mask high, middle, low vectors
// - Mask read loads accumulator with interrupt status word
// - Status bits 6,5,4 show high, middle, low pending
// - Status bit 3 shows global interrupt enable
// - Status bits 2,1,0 show high, middle, low masks
// - Address/data lines hold third-state value during states four to six
// - Halt state works correctly with bus hold request asserted
// - Outputs undefined before first reset after power-up
package clrid_pkg;

   // ----------------------------------------
   // Opcodes
   // ----------------------------------------
   localparam logic [4:0] CLRID_OP_AND_REG = 5'h14;
   localparam logic [4:0] CLRID_OP_XOR_REG = 5'h15;
   localparam logic [4:0] CLRID_OP_OR_REG = 5'h16;
   localparam logic [4:0] CLRID_OP_CMP_REG = 5'h17;
   localparam logic [7:0] CLRID_OP_AND_IMM = 8'hE6;
   localparam logic [7:0] CLRID_OP_XOR_IMM = 8'hEE;
   localparam logic [7:0] CLRID_OP_OR_IMM = 8'hF6;
   localparam logic [7:0] CLRID_OP_CMP_IMM = 8'hFE;
   localparam logic [7:0] CLRID_OP_ROT_LEFT = 8'h07;
   localparam logic [7:0] CLRID_OP_ROT_RIGHT = 8'h0F;
   localparam logic [7:0] CLRID_OP_ROT_LEFT_C = 8'h17;
   localparam logic [7:0] CLRID_OP_ROT_RIGHT_C = 8'h1F;
   localparam logic [7:0] CLRID_OP_INVERT_ACC = 8'h2F;
   localparam logic [7:0] CLRID_OP_CARRY_SET = 8'h37;
   localparam logic [7:0] CLRID_OP_CARRY_INVERT = 8'h3F;
   localparam logic [7:0] CLRID_OP_DEC_ADJUST = 8'h27;
   localparam logic [7:0] CLRID_OP_INT_ENABLE = 8'hFB;
   localparam logic [7:0] CLRID_OP_INT_DISABLE = 8'hF3;
   localparam logic [7:0] CLRID_OP_NO_OP = 8'h00;
   localparam logic [7:0] CLRID_OP_MASK_READ = 8'h20;
   localparam logic [7:0] CLRID_OP_MASK_SET = 8'h30;
   localparam logic [7:0] CLRID_OP_HALT = 8'h76;

   // ----------------------------------------
   // Register select codes and word fields
   // ----------------------------------------
   localparam logic [2:0] CLRID_SEL_MEMORY = 3'h6;
   localparam logic [2:0] CLRID_SEL_ACC = 3'h7;
   localparam int CLRID_SET_LATCH_CLEAR_BIT = 4;
   localparam int CLRID_SET_MASK_WRITE_BIT = 3;
   localparam int CLRID_STAT_PEND_LSB = 4;
   localparam int CLRID_STAT_ENABLE_BIT = 3;

   // ----------------------------------------
   // Cycle counts and reset values
   // ----------------------------------------
   localparam logic [3:0] CLRID_CYC_SHORT = 4'h4;
   localparam logic [3:0] CLRID_CYC_MEM = 4'h7;
   localparam logic [3:0] CLRID_CYC_HALT = 4'h5;
   localparam logic [3:0] CLRID_BUS_HOLD_FIRST = 4'h4;
   localparam logic [3:0] CLRID_BUS_HOLD_LAST = 4'h6;
   localparam logic [7:0] CLRID_ACC_RESET = 8'h00;
   localparam logic [2:0] CLRID_MASK_RESET = 3'h7;

   // Flags: sign, zero, aux carry, parity, carry
   typedef struct packed {
      logic sign;
      logic zero;
      logic aux;
      logic parity;
      logic carry;
   } clrid_flags_type;

   typedef enum logic [3:0] {
      CLRID_FETCH = 4'b0001,
      CLRID_OPERAND = 4'b0010,
      CLRID_EXEC = 4'b0100,
      CLRID_HALTED = 4'b1000
   } clrid_state_type;

   // Fetch stream byte with its valid strobe
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } clrid_byte_type;

   typedef struct packed {
      logic [2:0] pending;
      logic [2:0] mask;
      logic high_edge;
      logic enable;
   } clrid_intr_type;

endpackage

// ---- clrid_core.sv ----
// Execution core for logical, rotate, special and control instructions
module clrid_core (
   input wire logic mclk,
   input wire logic resetn,
   input wire clrid_pkg::clrid_byte_type fetch_byte,
   input wire logic [7:0] reg_operand,
   input wire logic high_vector_request,
   input wire logic middle_vector_request,
   input wire logic low_vector_request,
   input wire logic bus_hold_request,
   output logic fetch_ready,
   output logic [2:0] reg_select,
   output logic [7:0] accumulator,
   output clrid_pkg::clrid_flags_type flags,
   output clrid_pkg::clrid_intr_type intr_state,
   output logic [7:0] ad_lines,
   output logic halted,
   output logic bus_hold_ack,
   output logic done
);
   import clrid_pkg::*;

   typedef struct packed {
      clrid_state_type state;
      logic [7:0] opcode;
      logic [3:0] cycles;
      logic [3:0] bus_state;
      logic [7:0] acc;
      clrid_flags_type fl;
      clrid_intr_type intr;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic high_prev;
      logic hold1;
      logic hold2;
      logic [7:0] ad;
      logic [7:0] arg;
      logic ready;
      logic [2:0] sel;
      logic done;
      logic hold_ack;
   } clrid_core_type;

   clrid_core_type st;
   clrid_core_type next_st;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic clrid_flags_type logic_flags(input logic [7:0] r, input logic aux);
      clrid_flags_type f;
      f.sign = r[7];
      f.zero = (r == 8'h00);
      f.aux = aux;
      f.parity = ~^r;
      f.carry = 1'b0;
      return f;
   endfunction

   logic [8:0] diff;
   logic [7:0] operand;
   logic [7:0] result;
   logic [8:0] daa_sum;
   logic [7:0] daa_add;

   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      operand = 8'h00;
      result = 8'h00;
      diff = 9'h000;
      daa_add = 8'h00;
      daa_sum = 9'h000;
      // Pins from outside pass two flops first
      next_st.sync1 = {high_vector_request, middle_vector_request, low_vector_request};
      next_st.sync2 = st.sync1;
      next_st.hold1 = bus_hold_request;
      next_st.hold2 = st.hold1;
      next_st.high_prev = st.sync2[2];
      // Middle/low pending are level; high is an edge latch, set at the end
      next_st.intr.pending = {st.intr.high_edge, st.sync2[1:0]};
      // Bus state counter: address/data keep their third-state value afterwards;
      // it wraps before the case so a fetch in the last state restarts it
      if (st.bus_state == CLRID_BUS_HOLD_LAST) begin
         next_st.bus_state = 4'h0;
      end else if (st.bus_state != 4'h0) begin
         next_st.bus_state = st.bus_state + 4'h1;
      end
      if (st.bus_state < 4'h3) begin
         next_st.ad = st.acc;
      end
      next_st.hold_ack = 1'b0;
      case (st.state)
         CLRID_FETCH: begin
            next_st.ready = 1'b1;
            if (fetch_byte.valid && st.ready) begin
               next_st.opcode = fetch_byte.data;
               next_st.sel = fetch_byte.data[2:0];
               next_st.bus_state = 4'h1;
               next_st.ready = 1'b0;
               if (fetch_byte.data[7:5] == 3'b101 && fetch_byte.data[2:0] == CLRID_SEL_MEMORY) begin
                  next_st.cycles = CLRID_CYC_MEM;
                  next_st.state = CLRID_OPERAND;
                  next_st.ready = 1'b1;
               end else if (fetch_byte.data[7:6] == 2'b11 && fetch_byte.data[5:3] >= 3'h4
                  && fetch_byte.data[2:0] == 3'h6) begin
                  next_st.cycles = CLRID_CYC_MEM;
                  next_st.state = CLRID_OPERAND;
                  next_st.ready = 1'b1;
               end else if (fetch_byte.data == CLRID_OP_HALT) begin
                  next_st.cycles = CLRID_CYC_HALT;
                  next_st.state = CLRID_EXEC;
               end else begin
                  // One fixed count per op: no op of this group has a flag-dependent pair
                  next_st.cycles = CLRID_CYC_SHORT;
                  next_st.state = CLRID_EXEC;
               end
            end
         end
         CLRID_OPERAND: begin
            if (st.cycles != 4'h1) begin
               next_st.cycles = st.cycles - 4'h1;
            end
            if (fetch_byte.valid && st.ready) begin
               next_st.ready = 1'b0;
               next_st.opcode[2:0] = 3'h6;
               next_st.sel = CLRID_SEL_MEMORY;
               next_st.arg = fetch_byte.data; // Kept apart from the bus lines, which hold their own value
               next_st.state = CLRID_EXEC;
            end
         end
         CLRID_EXEC: begin
            next_st.cycles = st.cycles - 4'h1;
            if (st.cycles == 4'h1) begin
               // Operand: memory/immediate byte, else selected register or A
               if (st.sel == CLRID_SEL_MEMORY) begin
                  operand = st.arg;
               end else if (st.sel == CLRID_SEL_ACC) begin
                  operand = st.acc;
               end else begin
                  operand = reg_operand;
               end
               diff = {1'b0, st.acc} - {1'b0, operand};
               next_st.done = 1'b1;
               next_st.state = CLRID_FETCH;
               if (st.opcode[7:5] == 3'b101 || (st.opcode[7:5] == 3'b111 && st.opcode[2:0] == 3'h6)) begin
                  case (st.opcode[4:3])
                     2'b00: begin
                        result = st.acc & operand;
                        next_st.acc = result;
                        next_st.fl = logic_flags(result, st.acc[3] | operand[3]);
                     end
                     2'b01: begin
                        result = st.acc ^ operand;
                        next_st.acc = result;
                        next_st.fl = logic_flags(result, 1'b0);
                     end
                     2'b10: begin
                        result = st.acc | operand;
                        next_st.acc = result;
                        next_st.fl = logic_flags(result, 1'b0);
                     end
                     default: begin
                        next_st.fl = logic_flags(diff[7:0], st.acc[3:0] < operand[3:0]);
                        next_st.fl.carry = diff[8];
                     end
                  endcase
               end else begin
                  case (st.opcode)
                     CLRID_OP_ROT_LEFT: begin
                        next_st.acc = {st.acc[6:0], st.acc[7]};
                        next_st.fl.carry = st.acc[7];
                     end
                     CLRID_OP_ROT_RIGHT: begin
                        next_st.acc = {st.acc[0], st.acc[7:1]};
                        next_st.fl.carry = st.acc[0];
                     end
                     CLRID_OP_ROT_LEFT_C: begin
                        next_st.acc = {st.acc[6:0], st.fl.carry};
                        next_st.fl.carry = st.acc[7];
                     end
                     CLRID_OP_ROT_RIGHT_C: begin
                        next_st.acc = {st.fl.carry, st.acc[7:1]};
                        next_st.fl.carry = st.acc[0];
                     end
                     CLRID_OP_INVERT_ACC: next_st.acc = ~st.acc;
                     CLRID_OP_CARRY_SET: next_st.fl.carry = 1'b1;
                     CLRID_OP_CARRY_INVERT: next_st.fl.carry = ~st.fl.carry;
                     CLRID_OP_DEC_ADJUST: begin
                        daa_add[3:0] = (st.acc[3:0] > 4'h9 || st.fl.aux) ? 4'h6 : 4'h0;
                        daa_add[7:4] = (st.acc[7:4] > 4'h9 || st.fl.carry
                           || (st.acc[7:4] == 4'h9 && st.acc[3:0] > 4'h9)) ? 4'h6 : 4'h0;
                        daa_sum = {1'b0, st.acc} + {1'b0, daa_add};
                        next_st.acc = daa_sum[7:0];
                        next_st.fl = logic_flags(daa_sum[7:0], st.acc[3:0] > 4'h9);
                        next_st.fl.carry = st.fl.carry | daa_sum[8];
                     end
                     CLRID_OP_INT_ENABLE: next_st.intr.enable = 1'b1;
                     CLRID_OP_INT_DISABLE: next_st.intr.enable = 1'b0;
                     CLRID_OP_MASK_READ: begin
                        next_st.acc = {1'b0, st.intr.pending, st.intr.enable, st.intr.mask};
                     end
                     CLRID_OP_MASK_SET: begin
                        if (st.acc[CLRID_SET_MASK_WRITE_BIT]) begin
                           next_st.intr.mask = st.acc[2:0];
                        end
                        if (st.acc[CLRID_SET_LATCH_CLEAR_BIT]) begin
                           next_st.intr.high_edge = 1'b0;
                        end
                     end
                     CLRID_OP_HALT: begin
                        next_st.state = CLRID_HALTED;
                        next_st.done = 1'b0;
                     end
                     default: ;
                  endcase
               end
            end
         end
         CLRID_HALTED: begin
            // Bus hold is granted while halted and released cleanly
            next_st.hold_ack = st.hold2;
            if (st.intr.enable && |(st.intr.pending & ~st.intr.mask)) begin
               next_st.state = CLRID_FETCH;
               next_st.done = 1'b1;
            end
         end
         default: next_st.state = CLRID_FETCH;
      endcase
      // A new edge in the cycle of a clear wins, so no request is lost
      if (st.sync2[2] && !st.high_prev) begin
         next_st.intr.high_edge = 1'b1;
      end
   end

   // Outputs undefined before first reset; reset sets all state
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.state <= CLRID_FETCH;
         st.acc <= CLRID_ACC_RESET;
         st.intr.mask <= CLRID_MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign fetch_ready = st.ready;
   assign reg_select = st.sel;
   assign accumulator = st.acc;
   assign flags = st.fl;
   assign intr_state = st.intr;
   assign ad_lines = st.ad;
   assign halted = st.state[3];
   assign bus_hold_ack = st.hold_ack;
   assign done = st.done;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_maskset_load: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_MASK_SET && !st.acc[3]
      |=> $stable(st.intr.mask)) else $error("mask changed without write enable");
   chk_maskset_value: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_MASK_SET && st.acc[3]
      |=> st.intr.mask == $past(st.acc[2:0])) else $error("mask not loaded");
   chk_edge_clear: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_MASK_SET && st.acc[4]
      && !(st.sync2[2] && !st.high_prev) |=> !st.intr.high_edge) else $error("edge latch not cleared");
   chk_status_read: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_MASK_READ
      |=> st.acc == {1'b0, $past(st.intr.pending), $past(st.intr.enable), $past(st.intr.mask)})
      else $error("status word wrong");
   chk_short_length: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_FETCH && fetch_byte.valid && st.ready && fetch_byte.data[7:3] == CLRID_OP_CMP_REG
      && fetch_byte.data[2:0] != CLRID_SEL_MEMORY |=> st.cycles == CLRID_CYC_SHORT ##4 done)
      else $error("register op not 4 cycles");
   chk_mem_length: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_FETCH && fetch_byte.valid && st.ready && fetch_byte.data[7:5] == 3'b101
      && fetch_byte.data[2:0] == CLRID_SEL_MEMORY |=> st.cycles == CLRID_CYC_MEM)
      else $error("memory op not 7 cycles");
   chk_compare_keep: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode[7:3] == CLRID_OP_CMP_REG
      |=> $stable(st.acc)) else $error("compare changed accumulator");
   chk_rotate_left: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_ROT_LEFT
      |=> st.acc == {$past(st.acc[6:0]), $past(st.acc[7])} && st.fl.carry == $past(st.acc[7]))
      else $error("rotate left wrong");

   chk_rotate_right: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_ROT_RIGHT
      |=> st.acc == {$past(st.acc[0]), $past(st.acc[7:1])} && st.fl.carry == $past(st.acc[0]))
      else $error("rotate right wrong");

   chk_ad_hold: assert property (@(posedge mclk) disable iff (!resetn)
      st.bus_state >= 4'h3 && st.bus_state <= CLRID_BUS_HOLD_LAST
      |=> $stable(st.ad))
      else $error("bus lines moved in hold");

   chk_edge_set: assert property (@(posedge mclk) disable iff (!resetn)
      st.sync2[2] && !st.high_prev
      |=> st.intr.high_edge)
      else $error("high edge lost");

   chk_enable_set: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_INT_ENABLE
      |=> st.intr.enable)
      else $error("enable not set");

   chk_disable_clear: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_INT_DISABLE
      |=> !st.intr.enable)
      else $error("enable not cleared");

   chk_halt_length: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_FETCH && fetch_byte.valid && st.ready && fetch_byte.data == CLRID_OP_HALT
      |=> st.cycles == CLRID_CYC_HALT ##5 st.state == CLRID_HALTED)
      else $error("halt not 5 cycles");

   chk_imm_length: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_FETCH && fetch_byte.valid && st.ready && fetch_byte.data[7:5] == 3'b111
      && fetch_byte.data[2:0] == 3'h6 |=> st.cycles == CLRID_CYC_MEM && st.state == CLRID_OPERAND)
      else $error("immediate op not 7 cycles");

   chk_carry_set: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_CARRY_SET
      |=> st.fl.carry)
      else $error("carry not set");

   chk_invert_acc: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode == CLRID_OP_INVERT_ACC
      |=> st.acc == ~$past(st.acc))
      else $error("accumulator not inverted");

   chk_hold_ack_run: assert property (@(posedge mclk) disable iff (!resetn)
      st.state != CLRID_HALTED
      |=> !st.hold_ack)
      else $error("hold granted while running");

   chk_ready_exec: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC
      |-> !st.ready)
      else $error("byte accepted during execution");

   chk_logic_flags: assert property (@(posedge mclk) disable iff (!resetn)
      st.state == CLRID_EXEC && st.cycles == 4'h1 && st.opcode[7:5] == 3'b101 && st.opcode[4:3] != 2'b11
      |=> st.fl.parity == ~^st.acc && st.fl.zero == (st.acc == 8'h00) && !st.fl.carry)
      else $error("logical flags wrong");
endmodule

// ---- clrid_prog_model.sv ----
// Program memory and register bank standing in front of the execution core
module clrid_prog_model
   import clrid_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic fetch_ready,
   input wire logic [2:0] reg_select,
   output clrid_pkg::clrid_byte_type fetch_byte,
   output logic [7:0] reg_operand
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] bank [0:5];
   logic [7:0] pending_bytes [$];
   int cyc;
   int take_cyc;
   // Memory and accumulator codes get a moving pattern so a wrong select cannot match by luck
   assign reg_operand = (reg_select < CLRID_SEL_MEMORY) ? bank[reg_select] : 8'(cyc * 37);
   task automatic load(input logic [7:0] b);
      pending_bytes.push_back(b);
   endtask
   initial begin
      fetch_byte = '0;
      cyc = 0;
      take_cyc = 0;
      bank = '{8'h3C, 8'hC3, 8'h0F, 8'hF0, 8'h55, 8'hA1};
   end
   // A byte stays presented until taken; an idle stream toggles instead of repeating the last byte
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (resetn && fetch_byte.valid && fetch_ready) begin
         void'(pending_bytes.pop_front());
         take_cyc = cyc;
      end
      if (pending_bytes.size() > 0) fetch_byte <= {1'b1, pending_bytes[0]};
      else fetch_byte <= {1'b0, ~fetch_byte.data};
   end
endmodule

// ---- cpu_logic_rotate_intmask_decode_tb.sv ----
// Self-checking testbench for the logic, rotate and interrupt-mask execution core
module cpu_logic_rotate_intmask_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import clrid_pkg::*;
   logic mclk, resetn, req_high, req_mid, req_low, hold_req;
   clrid_byte_type fetch_byte;
   logic [7:0] reg_operand, accumulator, ad_lines;
   logic fetch_ready, halted, bus_hold_ack, done;
   logic [2:0] reg_select;
   clrid_flags_type flags;
   clrid_intr_type intr_state;
   int errors, comparisons;
   logic [7:0] acc_m;
   logic cy_m;
   logic [7:0] rot_seq [10] = '{8'h37, 8'h17, 8'h1F, 8'h07, 8'h0F, 8'h3F, 8'h17, 8'h2F, 8'h1F, 8'h00};

   clrid_core dut (.mclk(mclk), .resetn(resetn), .fetch_byte(fetch_byte), .reg_operand(reg_operand),
      .high_vector_request(req_high), .middle_vector_request(req_mid), .low_vector_request(req_low),
      .bus_hold_request(hold_req), .fetch_ready(fetch_ready), .reg_select(reg_select),
      .accumulator(accumulator), .flags(flags), .intr_state(intr_state), .ad_lines(ad_lines),
      .halted(halted), .bus_hold_ack(bus_hold_ack), .done(done));
   clrid_prog_model mdl (.mclk(mclk), .resetn(resetn), .fetch_ready(fetch_ready),
      .reg_select(reg_select), .fetch_byte(fetch_byte), .reg_operand(reg_operand));

   task automatic test_done();
      $display("comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_for(input string what, input logic want, ref logic sig);
      for (int n = 0; n < 30 && sig !== want; n++) begin
         @(posedge mclk);
         #1;
      end
      check(what, {7'h0, want}, {7'h0, sig});
   endtask
   // Done must come the op's count of edges after its opcode; the model's stamp moves to a second byte
   task automatic run(input logic [7:0] op, input logic [7:0] arg, input bit two_byte);
      int n;
      mdl.load(op);
      if (two_byte) mdl.load(arg);
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 40);
      check("done", 8'h01, {7'h0, done});
      if (!two_byte) check("latency", {4'h0, CLRID_CYC_SHORT}, 8'(mdl.cyc - mdl.take_cyc));
      else check("latency", {4'h0, CLRID_CYC_MEM} - 8'h01, 8'(mdl.cyc - mdl.take_cyc));
   endtask
   // Runs an op and compares accumulator and carry, and for logical ops zero, with the expected effect
   task automatic step(input logic [7:0] op, input logic [7:0] arg);
      logic [7:0] a, b, r;
      logic c;
      a = acc_m;
      c = cy_m;
      r = a;
      if (op[7:6] != 2'b00) begin
         b = (op[6] || op[2:0] == CLRID_SEL_MEMORY) ? arg : (op[2:0] == CLRID_SEL_ACC) ? a : mdl.bank[op[2:0]];
         case (op[4:3])
            2'b00: r = a & b;
            2'b01: r = a ^ b;
            2'b10: r = a | b;
            default: r = a;
         endcase
         c = (op[4:3] == 2'b11) ? (a < b) : 1'b0;
         run(op, arg, op[6] || op[2:0] == CLRID_SEL_MEMORY);
         check("zero", {7'h0, (op[4:3] == 2'b11) ? (a == b) : (r == 8'h00)}, {7'h0, flags.zero});
      end else begin
         case (op)
            CLRID_OP_ROT_LEFT: begin r = {a[6:0], a[7]}; c = a[7]; end
            CLRID_OP_ROT_RIGHT: begin r = {a[0], a[7:1]}; c = a[0]; end
            CLRID_OP_ROT_LEFT_C: begin r = {a[6:0], c}; c = a[7]; end
            CLRID_OP_ROT_RIGHT_C: begin r = {c, a[7:1]}; c = a[0]; end
            CLRID_OP_INVERT_ACC: r = ~a;
            CLRID_OP_CARRY_SET: c = 1'b1;
            CLRID_OP_CARRY_INVERT: c = ~c;
            CLRID_OP_DEC_ADJUST: begin
               // Aux is clear here: the bench adjusts only straight after an exclusive-or
               r = (a[3:0] > 4'h9) ? a + 8'h06 : a;
               if (r[7:4] > 4'h9 || c) begin
                  r = r + 8'h60;
                  c = 1'b1;
               end
            end
            default: ;
         endcase
         run(op, arg, 1'b0);
         // One edge on, the accumulator has moved but the bus lines still show the old value
         @(posedge mclk);
         #1;
         check("ad lines", a, ad_lines);
      end
      acc_m = r;
      cy_m = c;
      check("accumulator", acc_m, accumulator);
      check("carry", {7'h0, cy_m}, {7'h0, flags.carry});
   endtask
   task automatic setmask(input logic [7:0] word);
      step(CLRID_OP_AND_IMM, 8'h00);
      step(CLRID_OP_OR_IMM, word);
      run(CLRID_OP_MASK_SET, 8'h00, 1'b0);
   endtask
   // Bit 7 lies outside this block, so only the low seven status bits are compared
   task automatic status(input logic [7:0] exp);
      run(CLRID_OP_MASK_READ, 8'h00, 1'b0);
      check("status", exp, {1'b0, accumulator[6:0]});
      step(CLRID_OP_AND_IMM, 8'h00);
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #200000;
      errors++;
      $display("unexpected watchdog: expected finish, seen hang");
      test_done();
   end
   initial begin
      resetn = 1'b0;
      {req_high, req_mid, req_low, hold_req} = 4'h0;
      errors = 0;
      comparisons = 0;
      acc_m = 8'h00;
      cy_m = 1'b0;
      repeat (8) @(posedge mclk);
      check("reset acc", CLRID_ACC_RESET, accumulator);
      check("reset mask", {5'h0, CLRID_MASK_RESET}, {5'h0, intr_state.mask});
      check("reset ready", 8'h00, {7'h0, fetch_ready});
      resetn <= 1'b1;
      @(posedge mclk);
      $display("test reset done");
      for (int s = 0; s < 8; s++) begin
         for (int k = 0; k < 4; k++) begin
            step(CLRID_OP_OR_IMM, 8'h96 ^ 8'(s));
            step({3'b101, 2'(k), 3'(s)}, 8'h6D);
            check("select", {5'h0, 3'(s)}, {5'h0, reg_select});
            step({3'b111, 2'(k), 3'b110}, 8'h39);
         end
      end
      step(CLRID_OP_AND_IMM, 8'h00);
      step(CLRID_OP_OR_IMM, 8'h0F);
      step({CLRID_OP_CMP_REG, 3'h2}, 8'h00);
      step(CLRID_OP_CMP_IMM, 8'h10);
      $display("test logical done");
      step(CLRID_OP_OR_IMM, 8'h81);
      foreach (rot_seq[i]) step(rot_seq[i], 8'h00);
      step(CLRID_OP_AND_IMM, 8'h00);
      step(CLRID_OP_XOR_IMM, 8'h9B);
      step(CLRID_OP_DEC_ADJUST, 8'h00);
      $display("test rotate done");
      setmask(8'h0D);
      check("mask", 8'h05, {5'h0, intr_state.mask});
      setmask(8'h02);
      check("mask kept", 8'h05, {5'h0, intr_state.mask});
      run(CLRID_OP_INT_ENABLE, 8'h00, 1'b0);
      status(8'h0D);
      run(CLRID_OP_INT_DISABLE, 8'h00, 1'b0);
      status(8'h05);
      setmask(8'h08);
      status(8'h00);
      req_low <= 1'b1;
      req_mid <= 1'b1;
      repeat (4) @(posedge mclk);
      status(8'h30);
      req_high <= 1'b1;
      req_low <= 1'b0;
      req_mid <= 1'b0;
      repeat (4) @(posedge mclk);
      req_high <= 1'b0;
      repeat (4) @(posedge mclk);
      status(8'h40);
      setmask(8'h10);
      status(8'h00);
      $display("test mask done");
      run(CLRID_OP_INT_ENABLE, 8'h00, 1'b0);
      hold_req <= 1'b1;
      run(CLRID_OP_NO_OP, 8'h00, 1'b0);
      check("hold ack busy", 8'h00, {7'h0, bus_hold_ack});
      mdl.load(CLRID_OP_HALT);
      wait_for("halted", 1'b1, halted);
      wait_for("hold ack", 1'b1, bus_hold_ack);
      hold_req <= 1'b0;
      wait_for("hold release", 1'b0, bus_hold_ack);
      req_low <= 1'b1;
      wait_for("halt exit", 1'b0, halted);
      req_low <= 1'b0;
      step(CLRID_OP_OR_IMM, 8'h5A);
      $display("test halt done");
      test_done();
   end
endmodule
